// file: common/erx_pkg.sv
package erx_pkg;

  // Channel count and address width.
  localparam int ERX_CHANNELS = 8;
  localparam int ERX_AW       = 8;

  // Register byte offsets.
  localparam logic [7:0] ERX_OFS_GCF   = 8'h00;
  localparam logic [7:0] ERX_OFS_PWDN  = 8'h04;
  localparam logic [7:0] ERX_OFS_STAT  = 8'h08;
  localparam logic [7:0] ERX_OFS_ISTAT = 8'h0c;
  localparam logic [7:0] ERX_OFS_IMASK = 8'h10;

  // Field positions of global_config_reg.
  localparam int ERX_GCF_DUAL = 0;
  localparam int ERX_GCF_HDB3 = 1;
  localparam int ERX_GCF_ALARM_INSERT_ENABLE = 2;
  localparam int ERX_GCF_HOST = 3;

  // Values after reset.
  localparam logic [3:0]  ERX_GCF_RST   = 4'h2;
  localparam logic [7:0]  ERX_PWDN_RST  = 8'h00;
  localparam logic [15:0] ERX_IMASK_RST = 16'h0000;

  // Times, the cycle counts derived from them, and the mark and zero counts.
  localparam int ERX_PCLK_NS        = 100;
  localparam int ERX_MCLK_STALL_NS  = 2000;
  localparam int ERX_MCLK_STALL_CYC =
    (ERX_MCLK_STALL_NS + ERX_PCLK_NS - 1) / ERX_PCLK_NS;
  localparam int ERX_LOS_IDLE_NS    = 25600;
  localparam int ERX_LOS_IDLE_CYC   =
    (ERX_LOS_IDLE_NS + ERX_PCLK_NS - 1) / ERX_PCLK_NS;
  localparam int ERX_LOS_GAP_NS     = 6400;
  localparam int ERX_LOS_GAP_CYC    = ERX_LOS_GAP_NS / ERX_PCLK_NS;
  localparam int ERX_LOS_CLR_MARKS  = 4;
  localparam int ERX_EXZ_ZEROS      = 4;

  // State of the master clock monitor.
  typedef enum logic [1:0] {
    ERX_MCLK_RUN  = 2'b00,
    ERX_MCLK_HIGH = 2'b01,
    ERX_MCLK_LOW  = 2'b10
  } erx_mclk_t;

endpackage : erx_pkg

// file: common/erx_lane_if.sv
`timescale 1ns/100ps
interface erx_lane_if;
  logic data_q;
  logic pos_q;
  logic neg_q;
  logic viol_q;
  logic clk_q;
  logic raw_pos;
  logic raw_neg;
  logic los_q;
  logic viol_evt;

  modport chan (output data_q, pos_q, neg_q, viol_q, clk_q, raw_pos,
                raw_neg, los_q, viol_evt);
  modport top  (input  data_q, pos_q, neg_q, viol_q, clk_q, raw_pos,
                raw_neg, los_q, viol_evt);
endinterface : erx_lane_if

// file: hw/erx_chan.sv
`timescale 1ns/100ps
module erx_chan #(
  parameter int LOS_IDLE_CYC = erx_pkg::ERX_LOS_IDLE_CYC,
  parameter int LOS_GAP_CYC  = erx_pkg::ERX_LOS_GAP_CYC
) (
  // Clock and reset
  input  wire logic pclk,
  input  wire logic presetn,
  // Configuration on the same clock
  input  wire logic edge_sel,
  input  wire logic code_hdb3,
  input  wire logic dual_rail,
  input  wire logic ais_en,
  // Sliced line pulses and recovered clock, asynchronous
  input  wire logic line_in_tip,
  input  wire logic line_in_ring,
  input  wire logic line_clk,
  // Decoded lane towards the output stage
  erx_lane_if.chan  lane
);
  localparam int IW = $clog2(LOS_IDLE_CYC + 1);

  typedef struct packed {
    logic [1:0]    tip_s;
    logic [1:0]    ring_s;
    logic [1:0]    clk_s;
    logic          clk_q;
    logic          pos_seen;
    logic          neg_seen;
    logic          seen;
    logic          last_pos;
    logic [3:0]    data_sr;
    logic [3:0]    viol_sr;
    logic [2:0]    zrun;
    logic          ais_ph;
    logic          data_q;
    logic          pos_q;
    logic          neg_q;
    logic          viol_q;
    logic          viol_evt;
    logic          los_q;
    logic [IW-1:0] idle_cnt;
    logic [2:0]    marks;
  } erx_chan_st_t;

  erx_chan_st_t q;
  erx_chan_st_t n;
  logic         tick;
  logic         pos;
  logic         neg;
  logic         mark;
  logic         bpv;
  logic         sub_v;
  logic         sub_b;
  logic         v_in;
  logic [3:0]   sr;

  always_comb begin
    n          = q;
    n.tip_s    = {q.tip_s[0], line_in_tip};
    n.ring_s   = {q.ring_s[0], line_in_ring};
    n.clk_s    = {q.clk_s[0], line_clk};
    n.clk_q    = q.clk_s[1];
    n.viol_evt = 1'b0;
    tick  = edge_sel ? (q.clk_q & ~q.clk_s[1]) : (~q.clk_q & q.clk_s[1]);
    pos   = q.pos_seen | q.tip_s[1];
    neg   = q.neg_seen | q.ring_s[1];
    mark  = pos | neg;
    bpv   = mark & q.seen & (pos == q.last_pos);
    sub_v = code_hdb3 & bpv & (q.data_sr[2:0] == 3'h0);
    sub_b = code_hdb3 & bpv & (q.data_sr[2:0] == 3'h4);
    sr    = q.data_sr;
    if (sub_b) begin
      sr[2] = 1'b0;
    end
    v_in = bpv & ~sub_v & ~sub_b;
    if (code_hdb3 && !mark && q.zrun == 3'(erx_pkg::ERX_EXZ_ZEROS - 1)) begin
      v_in = 1'b1;
    end
    n.pos_seen = pos;
    n.neg_seen = neg;
    if (tick) begin
      n.pos_seen = 1'b0;
      n.neg_seen = 1'b0;
      n.data_sr  = {sr[2:0], mark & ~sub_v & ~sub_b};
      n.viol_sr  = {q.viol_sr[2:0], v_in};
      n.zrun     = mark ? 3'h0 : ((q.zrun == 3'h7) ? q.zrun : q.zrun + 3'h1);
      n.ais_ph   = ~q.ais_ph;
      if (mark) begin
        n.seen     = 1'b1;
        n.last_pos = pos;
      end
      if (ais_en && q.los_q) begin
        n.data_q = 1'b1;
        n.viol_q = 1'b0;
        n.pos_q  = q.ais_ph;
        n.neg_q  = ~q.ais_ph;
      end else begin
        n.data_q   = q.data_sr[3];
        n.viol_q   = ~dual_rail & q.viol_sr[3];
        n.viol_evt = ~dual_rail & q.viol_sr[3];
        n.pos_q    = pos;
        n.neg_q    = neg;
      end
      if (q.los_q && mark) begin
        n.marks = q.marks + 3'h1;
        if (q.marks == 3'(erx_pkg::ERX_LOS_CLR_MARKS - 1)) begin
          n.los_q = 1'b0;
          n.marks = 3'h0;
        end
      end
    end
    if (q.tip_s[1] | q.ring_s[1]) begin
      n.idle_cnt = '0;
    end else if (q.idle_cnt != IW'(LOS_IDLE_CYC)) begin
      n.idle_cnt = q.idle_cnt + IW'(1);
    end
    if (q.idle_cnt == IW'(LOS_GAP_CYC)) begin
      n.marks = 3'h0;
    end
    if (q.idle_cnt == IW'(LOS_IDLE_CYC - 1) && !(q.tip_s[1] | q.ring_s[1]))
    begin
      n.los_q = 1'b1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      q <= '0;
    end else begin
      q <= n;
    end
  end

  assign lane.data_q   = q.data_q;
  assign lane.pos_q    = q.pos_q;
  assign lane.neg_q    = q.neg_q;
  assign lane.viol_q   = q.viol_q;
  assign lane.clk_q    = q.clk_q;
  assign lane.raw_pos  = q.tip_s[1];
  assign lane.raw_neg  = q.ring_s[1];
  assign lane.los_q    = q.los_q;
  assign lane.viol_evt = q.viol_evt;

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  a_viol_hold_tick: assert property (
    !$past(tick) |-> $stable(q.viol_q))
    else $error("violation flag changed away from a launch edge");
  a_ami_bpv_only: assert property (
    (tick && !code_hdb3 && !bpv) |=> !q.viol_sr[0])
    else $error("AMI flagged a non bipolar violation");
  a_dual_pos_rail: assert property (
    (tick && !(ais_en && q.los_q)) |=> (q.pos_q == $past(pos)))
    else $error("positive rail does not follow the received pulse");
  a_los_set_idle: assert property (
    (q.idle_cnt == IW'(LOS_IDLE_CYC - 1) && !q.tip_s[1] && !q.ring_s[1])
      |=> q.los_q)
    else $error("loss of signal not raised after idle interval");
endmodule : erx_chan

// file: hw/erx_top.sv
// The APB interface to the registers and the placing of the registers are this design's own decisions.
`timescale 1ns/100ps
// What this block does
// - Single rail outputs AMI or HDB3 decoded NRZ.
// - Violations drive flag high one receive clock.
// - AMI decoder flags only bipolar violations.
// - Dual rail: rails mark positive and negative pulses.
// - Edge select picks falling or rising edge.
// - Raw rails active low with edge select low.
// - LOS keeps data, or AIS in host mode with alarm insert enabled.
// - Powered down receiver floats its data, flag and clock outputs.
// - Recovery mode outputs the recovered line clock.
// - Raw mode clock is XOR of rails.
// - Reference held high selects raw slicing.
// - Reference held low powers down all receivers.
// - No wait states without running reference.
// - LOS rises on no transitions, falls automatically.
module erx_top #(
  parameter int N            = erx_pkg::ERX_CHANNELS,
  parameter int LOS_IDLE_CYC = erx_pkg::ERX_LOS_IDLE_CYC,
  parameter int LOS_GAP_CYC  = erx_pkg::ERX_LOS_GAP_CYC
) (
  // APB slave
  input  wire logic                      pclk,
  input  wire logic                      presetn,
  input  wire logic                      psel,
  input  wire logic                      penable,
  input  wire logic                      pwrite,
  input  wire logic [erx_pkg::ERX_AW-1:0] paddr,
  input  wire logic [31:0]               pwdata,
  output      logic [31:0]               prdata,
  output      logic                      pready,
  output      logic                      pslverr,
  // Reference clock and edge select pins
  input  wire logic                      mclk,
  input  wire logic                      edge_polarity_select,
  // Line side per channel
  input  wire logic [N-1:0]              line_in_tip,
  input  wire logic [N-1:0]              line_in_ring,
  input  wire logic [N-1:0]              rx_line_clk,
  // Receive outputs per channel
  output      logic [N-1:0]              rx_nrz_data,
  output      logic [N-1:0]              rx_nrz_data_oe,
  output      logic [N-1:0]              rx_violation_flag,
  output      logic [N-1:0]              rx_violation_flag_oe,
  output      logic [N-1:0]              rx_clock_out,
  output      logic [N-1:0]              rx_clock_out_oe,
  output      logic [N-1:0]              loss_of_signal_out,
  // Interrupt
  output      logic                      irq
);
  localparam int SW = $clog2(erx_pkg::ERX_MCLK_STALL_CYC + 1);

  typedef struct packed {
    logic [1:0]         mclk_s;
    logic               mclk_q;
    logic [SW-1:0]      stall_cnt;
    erx_pkg::erx_mclk_t mstate;
    logic [1:0]         edge_s;
    logic [3:0]         global_config_reg;
    logic [N-1:0]       pwdn;
    logic [2*N-1:0]     ist;
    logic [2*N-1:0]     imask;
    logic [N-1:0]       los_d;
    logic [31:0]        prdata;
    logic               pslverr;
    logic [N-1:0]       dat;
    logic [N-1:0]       neg;
    logic [N-1:0]       clk;
    logic [N-1:0]       oe;
    logic [N-1:0]       los;
    logic               irq;
  } erx_top_st_t;

  erx_top_st_t  q;
  erx_top_st_t  n;
  logic         setup;
  logic         access;
  logic         hit;
  logic [31:0]  rd_mux;
  logic [N-1:0] nx_dat;
  logic [N-1:0] nx_neg;
  logic [N-1:0] nx_clk;
  logic [N-1:0] nx_oe;
  logic [N-1:0] los_w;
  logic [N-1:0] viol_w;
  logic [N-1:0] clk_w;
  logic [N-1:0] rawp_w;
  logic         raw_mode;
  logic         edge_sel;

  assign raw_mode = (q.mstate == erx_pkg::ERX_MCLK_HIGH);
  assign edge_sel = q.edge_s[1];

  genvar gi;
  generate
    for (gi = 0; gi < N; gi++) begin : g_ch
      erx_lane_if lane ();
      logic       down;
      logic       rp;
      logic       rn;

      erx_chan #(
        .LOS_IDLE_CYC (LOS_IDLE_CYC),
        .LOS_GAP_CYC  (LOS_GAP_CYC)
      ) u_chan (
        .pclk         (pclk),
        .presetn      (presetn),
        .edge_sel     (edge_sel),
        .code_hdb3    (q.global_config_reg[erx_pkg::ERX_GCF_HDB3]),
        .dual_rail    (q.global_config_reg[erx_pkg::ERX_GCF_DUAL]),
        .ais_en       (q.global_config_reg[erx_pkg::ERX_GCF_HOST] &
                       q.global_config_reg[erx_pkg::ERX_GCF_ALARM_INSERT_ENABLE]),
        .line_in_tip  (line_in_tip[gi]),
        .line_in_ring (line_in_ring[gi]),
        .line_clk     (rx_line_clk[gi]),
        .lane         (lane.chan)
      );

      assign down = q.pwdn[gi] | (q.mstate == erx_pkg::ERX_MCLK_LOW);
      // raw rail polarity from edge select
      assign rp   = edge_sel ? lane.raw_pos : ~lane.raw_pos;
      assign rn   = edge_sel ? lane.raw_neg : ~lane.raw_neg;
      assign nx_oe[gi]  = ~down;
      assign nx_dat[gi] = raw_mode ? rp :
                          (q.global_config_reg[erx_pkg::ERX_GCF_DUAL] ? lane.pos_q
                                                        : lane.data_q);
      assign nx_neg[gi] = raw_mode ? rn :
                          (q.global_config_reg[erx_pkg::ERX_GCF_DUAL] ? lane.neg_q
                                                        : lane.viol_q);
      assign nx_clk[gi] = raw_mode ? (rp ^ rn) : lane.clk_q;
      assign los_w[gi]  = lane.los_q;
      assign viol_w[gi] = lane.viol_evt;
      assign clk_w[gi]  = lane.clk_q;
      assign rawp_w[gi] = lane.raw_pos;
    end
  endgenerate

  always_comb begin
    setup  = psel & ~penable;
    access = psel & penable;
    hit    = 1'b1;
    rd_mux = 32'h0000_0000;
    case (paddr)
      erx_pkg::ERX_OFS_GCF:   rd_mux[3:0]     = q.global_config_reg;
      erx_pkg::ERX_OFS_PWDN:  rd_mux[N-1:0]   = q.pwdn;
      erx_pkg::ERX_OFS_STAT:  rd_mux[N+1:0]   = {q.mstate, q.los};
      erx_pkg::ERX_OFS_ISTAT: rd_mux[2*N-1:0] = q.ist;
      erx_pkg::ERX_OFS_IMASK: rd_mux[2*N-1:0] = q.imask;
      default:                hit             = 1'b0;
    endcase
  end

  always_comb begin
    n        = q;
    n.mclk_s = {q.mclk_s[0], mclk};
    n.mclk_q = q.mclk_s[1];
    n.edge_s = {q.edge_s[0], edge_polarity_select};
    if (q.mclk_s[1] != q.mclk_q) begin
      n.stall_cnt = '0;
    end else if (q.stall_cnt != SW'(erx_pkg::ERX_MCLK_STALL_CYC)) begin
      n.stall_cnt = q.stall_cnt + SW'(1);
    end
    case (q.mstate)
      erx_pkg::ERX_MCLK_RUN: begin
        // A reference edge in the same cycle keeps recovery mode.
        if (q.stall_cnt == SW'(erx_pkg::ERX_MCLK_STALL_CYC) &&
            q.mclk_s[1] == q.mclk_q) begin
          n.mstate = q.mclk_q ? erx_pkg::ERX_MCLK_HIGH
                              : erx_pkg::ERX_MCLK_LOW;
        end
      end
      erx_pkg::ERX_MCLK_HIGH,
      erx_pkg::ERX_MCLK_LOW: begin
        if (q.mclk_s[1] != q.mclk_q) begin
          n.mstate = erx_pkg::ERX_MCLK_RUN;
        end
      end
      default: begin
        n.mstate = erx_pkg::ERX_MCLK_RUN;
      end
    endcase

    if (setup) begin
      n.prdata  = rd_mux;
      n.pslverr = ~hit;
    end
    if (access && pwrite && hit) begin
      case (paddr)
        erx_pkg::ERX_OFS_GCF:   n.global_config_reg   = pwdata[3:0];
        erx_pkg::ERX_OFS_PWDN:  n.pwdn  = pwdata[N-1:0];
        erx_pkg::ERX_OFS_ISTAT: n.ist   = q.ist & ~pwdata[2*N-1:0];
        erx_pkg::ERX_OFS_IMASK: n.imask = pwdata[2*N-1:0];
        default:                n.global_config_reg   = q.global_config_reg;
      endcase
    end
    // A new event wins over a simultaneous clear.
    n.los_d = los_w;
    n.ist   = n.ist | {viol_w, los_w & ~q.los_d};
    n.irq   = |(n.ist & n.imask);

    n.dat = nx_dat;
    n.neg = nx_neg;
    n.clk = nx_clk;
    n.oe  = nx_oe;
    n.los = los_w;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      q        <= '0;
      q.mstate <= erx_pkg::ERX_MCLK_RUN;
      q.global_config_reg    <= erx_pkg::ERX_GCF_RST;
      q.pwdn   <= erx_pkg::ERX_PWDN_RST;
      q.imask  <= erx_pkg::ERX_IMASK_RST;
    end else begin
      q <= n;
    end
  end

  assign prdata               = q.prdata;
  assign pready               = 1'b1;
  assign pslverr              = q.pslverr;
  assign rx_nrz_data          = q.dat;
  assign rx_nrz_data_oe       = q.oe;
  assign rx_violation_flag    = q.neg;
  assign rx_violation_flag_oe = q.oe;
  assign rx_clock_out         = q.clk;
  assign rx_clock_out_oe      = q.oe;
  assign loss_of_signal_out   = q.los;
  assign irq                  = q.irq;

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  a_pwdn_float: assert property (
    q.pwdn[0] |=> !rx_nrz_data_oe[0] && !rx_clock_out_oe[0])
    else $error("powered down channel still drives");
  a_mclk_low_float: assert property (
    (q.mstate == erx_pkg::ERX_MCLK_LOW) |=> (rx_clock_out_oe == '0)
      && (rx_violation_flag_oe == '0))
    else $error("reference low but outputs driven");
  a_raw_xor_clock: assert property (
    (raw_mode && $past(raw_mode)) |->
      (rx_clock_out == (rx_nrz_data ^ rx_violation_flag)))
    else $error("raw clock is not the rail XOR");
  a_raw_polarity: assert property (
    raw_mode |=> rx_nrz_data[0] == ($past(edge_sel) ? $past(rawp_w[0])
                                                   : ~$past(rawp_w[0])))
    else $error("raw rail polarity wrong");
  a_rec_clock: assert property (
    (!raw_mode && q.mstate == erx_pkg::ERX_MCLK_RUN) |=>
      rx_clock_out[0] == $past(clk_w[0]))
    else $error("recovered clock not forwarded");
  a_mclk_stall: assert property (
    (q.mclk_q && $stable(q.mclk_s[1]))[*8] ##1 $stable(q.mclk_s[1])[*8]
      ##1 $stable(q.mclk_s[1])[*6] |=> raw_mode)
    else $error("held high reference did not enter raw mode");
  a_mclk_resume: assert property (
    (q.mclk_s[1] != q.mclk_q) |=> (q.mstate == erx_pkg::ERX_MCLK_RUN))
    else $error("reference edge did not restore recovery mode");
  a_los_sticky: assert property (
    (los_w[0] && !q.los_d[0]) |=> q.ist[0] ##1 (q.irq == q.imask[0]
      || q.ist != {{(2*N-1){1'b0}}, 1'b1}))
    else $error("loss of signal event not latched");
  a_apb_read_data: assert property (
    (setup && paddr == erx_pkg::ERX_OFS_GCF) |=>
      (prdata[3:0] == $past(q.global_config_reg)) && pready)
    else $error("register read data wrong");

  c_raw_mode:  cover property (raw_mode ##1 !raw_mode);
  c_viol_evt:  cover property (viol_w[0]);
  c_los_cycle: cover property ($rose(loss_of_signal_out[0]));
  c_irq_clear: cover property (irq ##[1:20] !irq);
endmodule : erx_top

// file: sim/erx_line_model.sv
`timescale 1ns/100ps
module erx_line_model #(
  parameter int N = 8
) (
  // Clock
  input  wire logic         pclk,
  // Line pins
  output      logic [N-1:0] tip,
  output      logic [N-1:0] ring,
  output      logic [N-1:0] lclk,
  // Receive outputs
  input  wire logic [N-1:0] pos,
  input  wire logic [N-1:0] neg,
  input  wire logic [N-1:0] rclk
);
  initial begin
    tip  = '0;
    ring = '0;
    lclk = '0;
  end

  // Holds the slicer outputs at a level, used with the raw slicing mode.
  task automatic hold(input int s);
    tip  <= {N{s > 0}};
    ring <= {N{s < 0}};
  endtask : hold

  // One 800 ns symbol; the line clock runs only while a symbol is sent.
  task automatic send(input  int s,
                      output logic [N-1:0] p,
                      output logic [N-1:0] n,
                      output logic [N-1:0] c);
    tip  <= {N{s > 0}};
    ring <= {N{s < 0}};
    @(posedge pclk);
    tip  <= '0;
    ring <= '0;
    @(posedge pclk);
    lclk <= '1;
    repeat (4) @(posedge pclk);
    lclk <= '0;
    @(posedge pclk);
    @(negedge pclk);
    p = pos;
    n = neg;
    c = rclk;
    @(posedge pclk);
  endtask : send
endmodule : erx_line_model

// file: sim/erx_top_bench.sv
`timescale 1ns/100ps
module erx_top_bench;
  localparam int N = 8;
  typedef struct {
    logic [7:0]  a;
    logic [31:0] wd;
    logic [31:0] rd;
    logic        err;
  } erx_row_t;
  logic         pclk;
  logic         presetn;
  logic         psel;
  logic         penable;
  logic         pwrite;
  logic [7:0]   paddr;
  logic [31:0]  pwdata;
  logic [31:0]  prdata;
  logic         pready;
  logic         pslverr;
  logic         mclk;
  logic         edge_sel;
  logic [N-1:0] tip;
  logic [N-1:0] ring;
  logic [N-1:0] lclk;
  logic [N-1:0] nrz;
  logic [N-1:0] nrz_oe;
  logic [N-1:0] viol;
  logic [N-1:0] viol_oe;
  logic [N-1:0] rclk;
  logic [N-1:0] rclk_oe;
  logic [N-1:0] los;
  logic         irq;
  logic [N-1:0] p;
  logic [N-1:0] n;
  logic [N-1:0] c;
  logic [31:0]  r;
  logic         e;
  int           mmode;
  int           error_cnt;
  int           compares;
  erx_row_t     rows [4] = '{'{8'h00, 32'hffffffff, 32'h0000000f, 1'b0},
                             '{8'h04, 32'hffffff5a, 32'h0000005a, 1'b0},
                             '{8'h10, 32'hffffffff, 32'h0000ffff, 1'b0},
                             '{8'h14, 32'h12345678, 32'h00000000, 1'b1}};
  int           seq_a [12] = '{1, 0, 0, 0, 0, -1, 0, 1, 0, -1, 0, 1};
  int           seq_b [12] = '{1, 0, -1, -1, 0, 1, 0, -1, 0, 1, 0, -1};
  int           ds [3] = '{1, -1, 0};

  erx_top #(.N(N), .LOS_IDLE_CYC(40), .LOS_GAP_CYC(20)) erx_top_i (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .mclk(mclk),
    .edge_polarity_select(edge_sel), .line_in_tip(tip),
    .line_in_ring(ring), .rx_line_clk(lclk), .rx_nrz_data(nrz),
    .rx_nrz_data_oe(nrz_oe), .rx_violation_flag(viol),
    .rx_violation_flag_oe(viol_oe), .rx_clock_out(rclk),
    .rx_clock_out_oe(rclk_oe), .loss_of_signal_out(los), .irq(irq));

  erx_line_model #(.N(N)) erx_line_model_i (
    .pclk(pclk), .tip(tip), .ring(ring), .lclk(lclk),
    .pos(nrz), .neg(viol), .rclk(rclk));

  initial begin
    pclk = 1'b0;
    forever #50 pclk = ~pclk;
  end

  // Reference clock: free running, or stuck high or low.
  // free running or stuck reference
  initial begin
    mclk = 1'b0;
    forever begin
      #244.1;
      mclk = (mmode == 0) ? ~mclk : (mmode == 1);
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      error_cnt++;
      $display("mismatch at %0t: got %h want %h", $time, got, exp);
    end
  endtask : chk

  task automatic apb(input logic wr, input logic [7:0] a,
                     input logic [31:0] wd);
    psel    <= 1'b1;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : apb

  task automatic rd(input logic [7:0] a, input logic [31:0] exp,
                    input logic [31:0] m = 32'hffffffff);
    apb(1'b0, a, 32'h0);
    chk(r & m, exp);
  endtask : rd

  task automatic do_reset();
    presetn <= 1'b0;
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
  endtask : do_reset

  // Single rail data leaves four receive clocks after its symbol.
  task automatic run_seq(input logic [31:0] g, input int s[12],
                         input int vi);
    do_reset();
    apb(1'b1, erx_pkg::ERX_OFS_GCF, g);
    for (int i = 0; i < 12; i++) begin
      erx_line_model_i.send(s[i], p, n, c);
      if (i >= 4) begin
        chk(p, {N{s[i-4] != 0}});
        chk(n, {N{i - 4 == vi}});
      end
    end
  endtask : run_seq

  task automatic print_verdict();
    $display("error_cnt %0d compares %0d", error_cnt, compares);
    if (error_cnt == 0 && compares > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : print_verdict

  initial begin
    #2000000;
    error_cnt++;
    print_verdict();
  end

  initial begin
    presetn  = 1'b0;
    psel     = 1'b0;
    penable  = 1'b0;
    pwrite   = 1'b0;
    paddr    = 8'h00;
    pwdata   = 32'h0;
    edge_sel = 1'b0;
    mmode    = 0;
    do_reset();
    rd(erx_pkg::ERX_OFS_GCF, 32'h00000002);
    rd(erx_pkg::ERX_OFS_PWDN, 32'h00000000);
    rd(erx_pkg::ERX_OFS_IMASK, 32'h00000000);
    foreach (rows[i]) begin
      apb(1'b1, rows[i].a, rows[i].wd);
      apb(1'b0, rows[i].a, 32'h0);
      chk(r, rows[i].rd);
      chk(e, rows[i].err);
    end
    // Dual rail with clock recovery.
    do_reset();
    apb(1'b1, erx_pkg::ERX_OFS_GCF, 32'h1);
    foreach (ds[i]) begin
      erx_line_model_i.send(ds[i], p, n, c);
      chk(p, {N{ds[i] > 0}});
      chk(n, {N{ds[i] < 0}});
      chk(c, {N{1'b1}});
    end
    // Falling edge timing: nothing moves until the line clock falls.
    edge_sel <= 1'b1;
    repeat (3) @(posedge pclk);
    erx_line_model_i.send(-1, p, n, c);
    chk(n, {N{1'b0}});
    repeat (3) @(posedge pclk);
    chk(viol, {N{1'b1}});
    edge_sel <= 1'b0;
    run_seq(32'h0, seq_a, -1);
    run_seq(32'h2, seq_a, 4);
    run_seq(32'h0, seq_b, 3);
    rd(erx_pkg::ERX_OFS_ISTAT, 32'h0000ff00);
    chk(irq, 1'b0);
    apb(1'b1, erx_pkg::ERX_OFS_IMASK, 32'h0000ff00);
    repeat (2) @(posedge pclk);
    chk(irq, 1'b1);
    apb(1'b1, erx_pkg::ERX_OFS_ISTAT, 32'h0000ff00);
    repeat (2) @(posedge pclk);
    chk(irq, 1'b0);
    repeat (60) @(posedge pclk);
    chk(los, {N{1'b1}});
    rd(erx_pkg::ERX_OFS_ISTAT, 32'h000000ff);
    apb(1'b1, erx_pkg::ERX_OFS_GCF, 32'h4);
    erx_line_model_i.send(0, p, n, c);
    chk(p, {N{1'b0}});
    apb(1'b1, erx_pkg::ERX_OFS_GCF, 32'hc);
    erx_line_model_i.send(0, p, n, c);
    erx_line_model_i.send(0, p, n, c);
    chk(p, {N{1'b1}});
    chk(n, {N{1'b0}});
    apb(1'b1, erx_pkg::ERX_OFS_GCF, 32'h0);
    for (int i = 0; i < 6; i++) begin
      erx_line_model_i.send(i[0] ? -1 : 1, p, n, c);
    end
    chk(los, {N{1'b0}});
    apb(1'b1, erx_pkg::ERX_OFS_PWDN, 32'h1);
    repeat (3) @(posedge pclk);
    chk(nrz_oe, 8'hfe);
    chk(viol_oe, 8'hfe);
    chk(rclk_oe, 8'hfe);
    apb(1'b1, erx_pkg::ERX_OFS_PWDN, 32'h0);
    // Raw slicing with the reference stuck high.
    apb(1'b1, erx_pkg::ERX_OFS_GCF, 32'h1);
    mmode = 1;
    erx_line_model_i.hold(1);
    repeat (40) @(posedge pclk);
    rd(erx_pkg::ERX_OFS_STAT, 32'h00000100, 32'h00000300);
    chk(nrz, {N{1'b0}});
    chk(viol, {N{1'b1}});
    chk(rclk, {N{1'b1}});
    edge_sel <= 1'b1;
    repeat (10) @(posedge pclk);
    chk(nrz, {N{1'b1}});
    chk(viol, {N{1'b0}});
    chk(rclk, {N{1'b1}});
    mmode = 2;
    repeat (40) @(posedge pclk);
    chk(nrz_oe | viol_oe | rclk_oe, 8'h00);
    rd(erx_pkg::ERX_OFS_STAT, 32'h00000200, 32'h00000300);
    chk(pready, 1'b1);
    print_verdict();
  end
endmodule : erx_top_bench
